/* File: dv/dmso_cu_model.sv */
// control unit model: acknowledges attention and sequences module power
`timescale 1ns/100ps
module dmso_cu_model (
    input wire logic i_clock,
    input wire logic i_ack_en,
    input wire logic i_power_off,
    input wire logic [7:0] i_attn,
    input wire logic i_heads_ext,
    output logic o_read_gate = 1'b0,
    output logic o_dc_on = 1'b1,
    output logic o_sequence_pick = 1'b1
);
    always @(posedge i_clock) begin
        o_read_gate <= i_ack_en && (i_attn != 8'h00);
        o_dc_on <= !i_power_off || i_heads_ext;
        // sequence pick dropped at power off
        o_sequence_pick <= !i_power_off;
    end
endmodule : dmso_cu_model

/* File: dv/dmso_status_monitor.sv */
// concurrent checks on the status outputs of one disk module
`timescale 1ns/100ps
module dmso_status_monitor
    import dmso_pkg::*;
#(
    parameter int unsigned SEEK_TIMEOUT_CYCLES = DMSO_SEEK_TIMEOUT_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire dmso_pins_type i_pins,
    input wire logic [DMSO_PLUG_WIDTH-1:0] i_id_plug,
    input wire logic i_set_cylinder,
    input wire logic [DMSO_CYL_WIDTH-1:0] i_cylinder_value,
    input wire logic i_seek_start,
    input wire logic i_read_gate,
    input wire logic i_cylinder_op,
    input wire logic [DMSO_HEAD_WIDTH-1:0] i_head_select,
    input wire logic [DMSO_CYL_WIDTH-1:0] o_cylinder_position_lines,
    input wire logic [DMSO_ATTN_LINES-1:0] o_gated_attention,
    input wire dmso_status_type o_status,
    input wire logic o_heads_extended,
    input wire logic o_operation_refused
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    AST_SEL_GATE: assert property (
        !o_status.selected |-> o_status == '0 && o_cylinder_position_lines == 8'h00)
        else $error("qualified output active while unselected");
    AST_SEL_LINE: assert property (
        $rose(i_pins.select) |-> ##[2:6] o_status.selected)
        else $error("selected line not raised");
    AST_ATTN_LINE: assert property (
        o_gated_attention != 8'h00 |-> o_gated_attention == (8'h01 << i_id_plug))
        else $error("attention on wrong line");
    AST_CYL_LOAD: assert property (
        i_set_cylinder && o_status.selected && !o_status.unsafe
        |-> ##2 o_cylinder_position_lines == $past(i_cylinder_value, 2))
        else $error("cylinder lines not loaded");
    AST_REFUSE: assert property (
        o_operation_refused |-> $past(i_set_cylinder) || $past(i_seek_start))
        else $error("refusal without request");
    AST_ON_LINE: assert property (
        o_status.on_line |-> !o_status.busy && o_heads_extended)
        else $error("on line while busy or retracted");
    AST_EOC: assert property (
        $rose(o_status.end_of_cylinder) |-> $past(i_cylinder_op, 2))
        else $error("end of cylinder outside cylinder operation");
    AST_WSENSE: assert property (
        $rose(i_pins.writing) && o_status.selected ##1 i_pins.writing [*6]
        |-> o_status.write_sense)
        else $error("write sense missing");
endmodule : dmso_status_monitor

/* File: dv/dmso_status_tb.sv */
// self-checking bench for the disk module status outputs
`timescale 1ns/100ps
module dmso_status_tb;
    import dmso_pkg::*;
    logic i_clock = 0, i_sys_rst = 1, i_set_cylinder = 0, i_seek_start = 0, i_cylinder_op = 0;
    logic ack_en = 0, power_off = 0, i_read_gate, dc_on, seq_pick, hit;
    dmso_pins_type i_pins = '0;
    logic [2:0] i_id_plug = 3'h5;
    logic [7:0] i_cylinder_value = 8'h00, o_cylinder_position_lines, o_gated_attention;
    logic [4:0] i_head_select = 5'h00;
    logic [7:0] dmso_vals [3] = '{8'h01, 8'h80, 8'ha5};
    dmso_status_type o_status;
    logic o_heads_extended, o_operation_refused;
    int n_mismatch = 0, n_tests = 0, k;
    always #10 i_clock = ~i_clock;
    dmso_status #(.SEEK_TIMEOUT_CYCLES(50)) dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_pins(i_pins), .i_id_plug(i_id_plug), .i_set_cylinder(i_set_cylinder),
        .i_cylinder_value(i_cylinder_value), .i_seek_start(i_seek_start),
        .i_read_gate(i_read_gate), .i_cylinder_op(i_cylinder_op), .i_head_select(i_head_select),
        .o_cylinder_position_lines(o_cylinder_position_lines),
        .o_gated_attention(o_gated_attention),
        .o_status(o_status), .o_heads_extended(o_heads_extended),
        .o_operation_refused(o_operation_refused));
    dmso_cu_model cu (.i_clock(i_clock), .i_ack_en(ack_en), .i_power_off(power_off),
        .i_attn(o_gated_attention), .i_heads_ext(o_heads_extended), .o_read_gate(i_read_gate),
        .o_dc_on(dc_on), .o_sequence_pick(seq_pick));
    task tick(input int n); repeat (n) @(posedge i_clock); #2; endtask : tick
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task pulse_seek(); i_seek_start = 1; tick(1); i_seek_start = 0; endtask : pulse_seek
    task wait_attn();
        for (k = 0; k < 200 && o_gated_attention === 8'h00; k++) tick(1);
        if (k == 200) begin n_mismatch++; finish_test(); end
    endtask : wait_attn
    initial begin
        tick(10); i_sys_rst = 0; tick(1);
        cmp(o_status, 0);
        i_pins.select = 1; tick(6); cmp(o_status.selected, 1);
        foreach (dmso_vals[j]) begin
            i_cylinder_value = dmso_vals[j]; i_set_cylinder = 1; tick(1); i_set_cylinder = 0;
            tick(3); cmp(o_cylinder_position_lines, dmso_vals[j]);
        end
        i_pins.select = 0; tick(6); cmp(o_cylinder_position_lines, 0);
        i_pins.select = 1; i_pins.seeking = 1; tick(6); pulse_seek(); tick(5);
        cmp(o_status.busy, 1);
        i_pins.detent = 1; i_pins.seeking = 0; wait_attn(); cmp(o_gated_attention, 8'h20);
        cmp({o_status.busy, o_status.seek_incomplete}, 2'h0);
        i_pins.detent = 0; i_pins.select = 0; tick(6); cmp(o_gated_attention, 8'h20);
        ack_en = 1; tick(4); cmp(o_gated_attention, 0);
        ack_en = 0; i_pins.select = 1; tick(6); pulse_seek(); wait_attn();
        cmp(k >= 50 && k <= 53, 1);
        cmp(o_status.seek_incomplete, 1);
        ack_en = 1; i_pins.unsafe = 1; tick(6); cmp(o_status.unsafe, 1);
        i_cylinder_value = 8'h3c; i_set_cylinder = 1; hit = 0;
        repeat (3) begin tick(1); i_set_cylinder = 0; hit |= o_operation_refused; end
        cmp(hit, 1);
        i_pins.unsafe = 0; tick(6); cmp(o_cylinder_position_lines, 8'ha5);
        i_cylinder_op = 1; i_head_select = 5'h13; tick(2); i_head_select = 5'h14; tick(3);
        cmp(o_status.end_of_cylinder, 1);
        i_cylinder_op = 0; tick(3); cmp(o_status.end_of_cylinder, 0);
        i_pins.writing = 1; i_pins.reading = 1; i_pins.read_data = 1; i_pins.heads_extended = 1;
        i_pins.ready = 1; i_pins.pack_change = 1; i_pins.index = 1; tick(8);
        cmp({o_status.index, o_status.write_sense, o_status.read_data}, 3'h7);
        cmp({o_status.on_line, o_status.pack_change}, 2'h3);
        i_pins.index = 0; i_pins.reading = 0; power_off = 1; tick(6);
        cmp({dc_on, seq_pick}, 2'h2);
        cmp({o_status.index, o_status.read_data}, 2'h0);
        i_pins.heads_extended = 0; tick(8);
        cmp({o_heads_extended, o_status.on_line, dc_on}, 0);
        finish_test();
    end
endmodule : dmso_status_tb
bind dmso_status dmso_status_monitor #(.SEEK_TIMEOUT_CYCLES(SEEK_TIMEOUT_CYCLES)) mon (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pins(i_pins), .i_id_plug(i_id_plug),
    .i_set_cylinder(i_set_cylinder), .i_cylinder_value(i_cylinder_value),
    .i_seek_start(i_seek_start), .i_read_gate(i_read_gate), .i_cylinder_op(i_cylinder_op),
    .i_head_select(i_head_select), .o_cylinder_position_lines(o_cylinder_position_lines),
    .o_gated_attention(o_gated_attention), .o_status(o_status),
    .o_heads_extended(o_heads_extended), .o_operation_refused(o_operation_refused));

/* File: rtl/dmso_pkg.sv */
// constants, types and functional notes for the disk module status outputs
// Functional notes
// R1: cylinder position shown on eight binary-weighted lines, weights 1 to 128.
// R2: cylinder lines driven only when selected; updated at set-cylinder time.
// R3: gated attention raised on seek complete or 600 ms seek timeout.
// R4: read gate clears gated attention.
// R5: gated attention ignores selection; routed to line chosen by id plug.
// R6: selected-module line asserted on own line while selected.
// R7: busy high while seeking, low when ready; driven only when selected.
// R8: one index pulse per revolution, selection qualified.
// R9: write sense asserted while the selected module writes the medium; the code holds it low while unsafe.
// R10: unsafe output asserted, selection qualified; operations refused while unsafe.
// R11: seek incomplete asserted if seek not complete within 600 ms, selection qualified.
// R12: end of cylinder raised when head register goes 19 to 20 in cylinder operation.
// R13: read data driven during reads, only while selected.
// R14: control unit keeps dc until every heads-extended line drops.
// R15: on-line asserted only when heads extended and ready, selection qualified.
// R16: control unit holds sequence pick while powered, starting motors in turn.
// R17: control unit opens controlled ground at power off to stop motors; the model has no ground line and only drops sequence pick.
// R18: pack change indication output provided.
// R19: one select line per module; id plug fixes which line is used.
// R20: unselected qualified outputs held inactive.
package dmso_pkg;
    localparam int unsigned DMSO_CLOCK_HZ = 50_000_000;
    localparam int unsigned DMSO_SEEK_TIMEOUT_MS = 600;
    localparam int unsigned DMSO_SEEK_TIMEOUT_CYCLES =
        DMSO_SEEK_TIMEOUT_MS * (DMSO_CLOCK_HZ / 1000);
    localparam int unsigned DMSO_CYL_WIDTH = 8;
    localparam int unsigned DMSO_HEAD_WIDTH = 5;
    localparam logic [4:0] DMSO_HEAD_LAST = 5'h13;
    localparam logic [4:0] DMSO_HEAD_END = 5'h14;
    localparam int unsigned DMSO_PLUG_WIDTH = 3;
    localparam int unsigned DMSO_ATTN_LINES = 8;

    // raw pin-side module events, all from outside the clock domain
    typedef struct packed {
        logic select;
        logic seeking;
        logic detent;
        logic index;
        logic writing;
        logic reading;
        logic read_data;
        logic unsafe;
        logic heads_extended;
        logic ready;
        logic pack_change;
    } dmso_pins_type;

    // selection-qualified status group
    typedef struct packed {
        logic selected;
        logic busy;
        logic index;
        logic write_sense;
        logic unsafe;
        logic seek_incomplete;
        logic end_of_cylinder;
        logic read_data;
        logic on_line;
        logic pack_change;
    } dmso_status_type;

    typedef enum logic [1:0] {
        DMSO_IDLE = 2'h0,
        DMSO_SEEK = 2'h1,
        DMSO_DONE = 2'h3
    } dmso_seek_type;
endpackage : dmso_pkg

/* File: rtl/dmso_status.sv */
// status output logic of one disk module toward the storage control unit
`timescale 1ns/100ps
module dmso_status
    import dmso_pkg::*;
#(
    parameter int unsigned SEEK_TIMEOUT_CYCLES = DMSO_SEEK_TIMEOUT_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire dmso_pins_type i_pins,
    input wire logic [DMSO_PLUG_WIDTH-1:0] i_id_plug,
    input wire logic i_set_cylinder,
    input wire logic [DMSO_CYL_WIDTH-1:0] i_cylinder_value,
    input wire logic i_seek_start,
    input wire logic i_read_gate,
    input wire logic i_cylinder_op,
    input wire logic [DMSO_HEAD_WIDTH-1:0] i_head_select,
    output logic [DMSO_CYL_WIDTH-1:0] o_cylinder_position_lines,
    output logic [DMSO_ATTN_LINES-1:0] o_gated_attention,
    output dmso_status_type o_status,
    output logic o_heads_extended,
    output logic o_operation_refused
);
    localparam int unsigned NPIN = $bits(dmso_pins_type);
    localparam int unsigned TW = $clog2(SEEK_TIMEOUT_CYCLES + 1);

    // three-stage synchronisers; only stages two and three are compared
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] clean;
    dmso_pins_type pin;
    logic [NPIN-1:0] next_clean;
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_filt
            assign next_clean[g] = (sync2[g] == sync3[g]) ? sync3[g] : clean[g];
        end
    endgenerate
    assign pin = dmso_pins_type'(clean);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            clean <= '0;
        end else begin
            sync1 <= i_pins;
            sync2 <= sync1;
            sync3 <= sync2;
            clean <= next_clean;
        end
    end

    // R19 the synchronised select line gates every qualified output
    logic sel;
    assign sel = pin.select;

    // cylinder register, loaded at set-cylinder time
    logic [DMSO_CYL_WIDTH-1:0] cylinder;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cylinder <= '0;
        end else if (i_set_cylinder && !pin.unsafe) begin
            cylinder <= i_cylinder_value;
        end
    end

    // seek supervision
    dmso_seek_type seek_state;
    dmso_seek_type next_seek_state;
    logic [TW-1:0] seek_count;
    logic timeout;
    logic seek_ok;
    logic seek_go;
    assign seek_go = i_seek_start && !pin.unsafe;
    assign timeout = (seek_state == DMSO_SEEK) && (seek_count == TW'(SEEK_TIMEOUT_CYCLES));
    assign seek_ok = (seek_state == DMSO_SEEK) && pin.detent && !timeout;

    always_comb begin
        next_seek_state = seek_state;
        case (seek_state)
            DMSO_IDLE: if (seek_go) next_seek_state = DMSO_SEEK;
            DMSO_SEEK: if (seek_ok || timeout) next_seek_state = DMSO_DONE;
            DMSO_DONE: if (seek_go) next_seek_state = DMSO_SEEK;
            default: next_seek_state = DMSO_IDLE;
        endcase
    end

    logic attention;
    logic seek_fail;
    logic count_run;
    // a repeated seek command restarts the timeout window
    assign count_run = (seek_state == DMSO_SEEK) && !seek_go;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            seek_state <= DMSO_IDLE;
            seek_count <= '0;
        end else begin
            seek_state <= next_seek_state;
            seek_count <= count_run ? seek_count + 1'h1 : '0;
        end
    end

    // R3 raise attention; set beats the read-gate clear
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            attention <= 1'h0;
        end else if (seek_ok || timeout) begin
            attention <= 1'h1;
        // R4 read gate clears
        end else if (i_read_gate) begin
            attention <= 1'h0;
        end
    end

    // R11 timeout flag, held until the next accepted seek
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            seek_fail <= 1'h0;
        end else if (timeout) begin
            seek_fail <= 1'h1;
        end else if (seek_go) begin
            seek_fail <= 1'h0;
        end
    end

    // R12 head register passing 19 to 20
    logic [DMSO_HEAD_WIDTH-1:0] head_prev;
    logic head_wrap;
    logic eoc;
    assign head_wrap = (head_prev == DMSO_HEAD_LAST) && (i_head_select == DMSO_HEAD_END);
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            head_prev <= '0;
        end else begin
            head_prev <= i_head_select;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            eoc <= 1'h0;
        end else if (i_cylinder_op && head_wrap) begin
            eoc <= 1'h1;
        end else if (!i_cylinder_op) begin
            eoc <= 1'h0;
        end
    end

    // R5 attention on the plug-chosen line, not selection gated
    logic [DMSO_ATTN_LINES-1:0] next_attn;
    assign next_attn = attention ? (DMSO_ATTN_LINES'(1) << i_id_plug) : '0;

    // R20 every qualified output forced inactive when unselected
    dmso_status_type next_status;
    logic busy_now;
    assign busy_now = pin.seeking || (seek_state == DMSO_SEEK);
    always_comb begin
        next_status = '0;
        if (sel) begin
            // R6 selected line
            next_status.selected = 1'b1;
            // R7 busy while seeking
            next_status.busy = busy_now;
            // R8 index pulse
            next_status.index = pin.index;
            // R9 write sense, suppressed when unsafe
            next_status.write_sense = pin.writing && !pin.unsafe;
            // R10 unsafe indication
            next_status.unsafe = pin.unsafe;
            next_status.seek_incomplete = seek_fail;
            next_status.end_of_cylinder = eoc;
            // R13 read data during reads only
            next_status.read_data = pin.reading && pin.read_data;
            // R15 on-line when extended, ready and not busy
            next_status.on_line = pin.heads_extended && pin.ready && !busy_now;
            // R18 pack change
            next_status.pack_change = pin.pack_change;
        end
    end

    // R1 R2 cylinder lines gated by select
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_cylinder_position_lines <= '0;
        end else begin
            o_cylinder_position_lines <= sel ? cylinder : '0;
        end
    end

    // R5 attention line, never gated by select
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_gated_attention <= '0;
        end else begin
            o_gated_attention <= next_attn;
        end
    end

    // R20 qualified group registered as one word
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_status <= '0;
        end else begin
            o_status <= next_status;
        end
    end

    // R14 heads extended ungated, for power-down sequencing
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_heads_extended <= 1'h0;
        end else begin
            o_heads_extended <= pin.heads_extended;
        end
    end

    // R10 refuse operations while unsafe
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_operation_refused <= 1'h0;
        end else begin
            o_operation_refused <= pin.unsafe && (i_set_cylinder || i_seek_start);
        end
    end
endmodule : dmso_status
